// File: rtl/cen_notifier.v
// camera event notifier: event capture, enables, message queue, ahb regs
//
// Contract
// (RQ1) event_pick selects one event type; notify writes apply only to it
// (RQ2) frame_begin_evt raised when an exposure delay period begins
// (RQ3) exposure_begin_evt raised when sensor exposure starts
// (RQ4) exposure_finish_evt raised when sensor exposure ends
// (RQ5) acq_rearm_evt raised when acquisition start is accepted again
// (RQ6) accepted_trigger_evt raised for every valid frame trigger
// (RQ7) trigger in invalid region rejected, no frame, rejected_trigger_evt
// (RQ8) lost_image_evt raised when an image is dropped for lack of memory
// (RQ9) counter_terminal_evt raised when counter 1 reaches counter_limit
// (RQ10) separate rise and fall events on input lines a and b
// (RQ11) on message overflow disable all enabled events, raise overflow
// (RQ12) host must re-enable needed events after an overflow
// (RQ13) one notify_setting per event type, written through event_pick
// (RQ14) notify_setting off suppresses every message of that type; the overflow message is sent even while its setting is off
// (RQ15) notify_setting on gives one message per occurrence
// (RQ16) legacy_notify_value behaves exactly like on
// (RQ17) messages queued in occurrence order; all settings off at reset; the code queues types that are pending together lowest code first
`timescale 1ns/10ps
`include "cen_defs.vh"
module cen_notifier #(
  parameter FIFO_DEPTH = `CEN_FIFO_DEPTH,
  parameter FIFO_AW = 3,
  parameter CNT_W = 16
) (
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  output reg irq,
  // acquisition sources, one-cycle pulses except in_a and in_b, which are levels
  input wire exp_delay_start,
  input wire exposure_start,
  input wire exposure_end,
  input wire acq_begin_cmd_ok,
  input wire frame_trigger,
  input wire trigger_invalid_region,
  input wire image_dropped,
  input wire counter_tick,
  input wire in_a,
  input wire in_b,
  // frame acquisition start, only for accepted triggers
  output reg frame_acq_start,
  // control channel message port
  output reg msg_valid,
  output reg [3:0] msg_code,
  input wire msg_ready
);

  localparam NE = `CEN_NUM_EVT;

  // ---------------------------------------------------------------
  // ahb address phase capture
  // ---------------------------------------------------------------
  reg wr_pend;
  reg [7:0] wr_addr;
  wire addr_phase;
  wire rd_take;
  assign addr_phase = hsel & hready & htrans[1];
  assign rd_take = addr_phase & ~hwrite;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      // zero wait states, every transfer answered okay
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend <= addr_phase & hwrite;
      if (addr_phase) begin
        wr_addr <= haddr;
      end
    end
  end

  wire wr_pick;
  wire wr_notify;
  wire wr_limit;
  wire wr_stat;
  wire wr_mask;
  assign wr_pick = wr_pend & (wr_addr == `CEN_OFS_PICK);
  assign wr_notify = wr_pend & (wr_addr == `CEN_OFS_NOTIFY);
  assign wr_limit = wr_pend & (wr_addr == `CEN_OFS_LIMIT);
  assign wr_stat = wr_pend & (wr_addr == `CEN_OFS_IRQ_STAT);
  assign wr_mask = wr_pend & (wr_addr == `CEN_OFS_IRQ_MASK);

  // ---------------------------------------------------------------
  // software settings
  // ---------------------------------------------------------------
  reg [3:0] event_pick;
  reg [CNT_W-1:0] counter_limit;
  reg [`CEN_IRQ_W-1:0] irq_mask;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      event_pick <= `CEN_EVT_FRAME_BEGIN;
      counter_limit <= `CEN_LIMIT_RESET;
      irq_mask <= {`CEN_IRQ_W{1'b0}};
    end else begin
      // codes past the last event type are ignored
      if (wr_pick && hwdata[3:0] < NE[3:0]) begin
        event_pick <= hwdata[3:0]; // RQ1
      end
      if (wr_limit) begin
        counter_limit <= hwdata[CNT_W-1:0];
      end
      if (wr_mask) begin
        irq_mask <= hwdata[`CEN_IRQ_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // event sources
  // ---------------------------------------------------------------
  wire [1:0] line_rise;
  wire [1:0] line_fall;

  cen_edge_detect #(
    .N(2)
  ) u_edges (
    .hclk(hclk),
    .hresetn(hresetn),
    .line_in({in_b, in_a}),
    .rise(line_rise),
    .fall(line_fall)
  );

  // counter 1: counts ticks, fires and restarts at counter_limit
  reg [CNT_W-1:0] cnt;
  reg cnt_term;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= {CNT_W{1'b0}};
      cnt_term <= 1'b0;
    end else begin
      cnt_term <= 1'b0;
      if (counter_tick && counter_limit != {CNT_W{1'b0}}) begin
        if (cnt + 1'b1 >= counter_limit) begin
          cnt <= {CNT_W{1'b0}};
          cnt_term <= 1'b1; // RQ9
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
    end
  end

  // triggers inside the invalid region never start a frame
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_acq_start <= 1'b0;
    end else begin
      frame_acq_start <= frame_trigger & ~trigger_invalid_region; // RQ7
    end
  end

  reg [NE-1:0] occur;
  always @* begin
    occur = {NE{1'b0}};
    occur[`CEN_EVT_FRAME_BEGIN] = exp_delay_start; // RQ2
    occur[`CEN_EVT_EXP_BEGIN] = exposure_start; // RQ3
    occur[`CEN_EVT_EXP_FINISH] = exposure_end; // RQ4
    occur[`CEN_EVT_ACQ_REARM] = acq_begin_cmd_ok; // RQ5
    occur[`CEN_EVT_TRIG_OK] = frame_trigger & ~trigger_invalid_region; // RQ6
    occur[`CEN_EVT_TRIG_REJ] = frame_trigger & trigger_invalid_region; // RQ7
    occur[`CEN_EVT_LOST_IMAGE] = image_dropped; // RQ8
    occur[`CEN_EVT_CNT_TERM] = cnt_term; // RQ9
    occur[`CEN_EVT_IN_A_RISE] = line_rise[0]; // RQ10
    occur[`CEN_EVT_IN_A_FALL] = line_fall[0]; // RQ10
    occur[`CEN_EVT_IN_B_RISE] = line_rise[1]; // RQ10
    occur[`CEN_EVT_IN_B_FALL] = line_fall[1]; // RQ10
    occur[`CEN_EVT_OVERFLOW] = 1'b0;
  end

  // ---------------------------------------------------------------
  // per-type notify settings and pending messages
  // ---------------------------------------------------------------
  reg [1:0] notify_setting [0:NE-1];
  reg [NE-1:0] enabled;
  reg [NE-1:0] pend;
  reg [NE-1:0] pend_clr;
  reg [3:0] push_code;
  reg push_req;
  wire fifo_in_ready;
  wire overflow;
  integer k;

  // a message is lost when its type is still waiting from last time
  assign overflow = |(occur & enabled & pend & ~pend_clr); // RQ11

  genvar g;
  generate
    for (g = 0; g < NE; g = g + 1) begin : g_evt
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          notify_setting[g] <= `CEN_NOTIFY_OFF; // RQ17
          pend[g] <= 1'b0;
        end else begin
          if (overflow) begin
            notify_setting[g] <= `CEN_NOTIFY_OFF; // RQ11
          end else if (wr_notify && event_pick == g &&
                       hwdata[1:0] != 2'h3) begin
            notify_setting[g] <= hwdata[1:0]; // RQ13
          end
          if (g == `CEN_EVT_OVERFLOW) begin
            // the overflow report itself is sent regardless of settings
            if (overflow) begin
              pend[g] <= 1'b1; // RQ11
            end else if (pend_clr[g]) begin
              pend[g] <= 1'b0;
            end
          end else if (occur[g] && enabled[g]) begin
            pend[g] <= 1'b1; // RQ15
          end else if (pend_clr[g]) begin
            pend[g] <= 1'b0;
          end
        end
      end
      always @* begin
        enabled[g] = (notify_setting[g] == `CEN_NOTIFY_ON) ||
                     (notify_setting[g] == `CEN_NOTIFY_LEGACY); // RQ16 RQ14
      end
    end
  endgenerate

  // one message per cycle enters the queue, lowest code first among
  // those pending together; this orders equal-cycle events by code
  always @* begin
    push_req = 1'b0;
    push_code = 4'h0;
    pend_clr = {NE{1'b0}};
    for (k = NE - 1; k >= 0; k = k - 1) begin
      if (pend[k]) begin
        push_req = 1'b1;
        push_code = k[3:0];
      end
    end
    if (push_req && fifo_in_ready) begin
      pend_clr[push_code] = 1'b1; // RQ17
    end
  end

  // ---------------------------------------------------------------
  // message queue and registered control channel port
  // ---------------------------------------------------------------
  wire fifo_out_valid;
  wire [3:0] fifo_out_data;
  wire [FIFO_AW:0] fifo_level;
  wire out_load;
  assign out_load = fifo_out_valid & (~msg_valid | msg_ready);

  cen_msg_fifo #(
    .W(4),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .hclk(hclk),
    .hresetn(hresetn),
    .in_valid(push_req),
    .in_ready(fifo_in_ready),
    .in_data(push_code),
    .out_valid(fifo_out_valid),
    .out_ready(out_load),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      msg_valid <= 1'b0;
      msg_code <= 4'h0;
    end else begin
      if (out_load) begin
        msg_valid <= 1'b1; // RQ17
        msg_code <= fifo_out_data;
      end else if (msg_ready) begin
        msg_valid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt status, write one to clear, set wins
  // ---------------------------------------------------------------
  reg [`CEN_IRQ_W-1:0] irq_stat;
  reg [`CEN_IRQ_W-1:0] irq_set;
  always @* begin
    irq_set = {`CEN_IRQ_W{1'b0}};
    irq_set[`CEN_IRQ_OVERFLOW] = overflow;
    irq_set[`CEN_IRQ_TRIG_REJ] = occur[`CEN_EVT_TRIG_REJ];
    irq_set[`CEN_IRQ_LOST_IMAGE] = occur[`CEN_EVT_LOST_IMAGE];
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat <= {`CEN_IRQ_W{1'b0}};
      irq <= 1'b0;
    end else begin
      if (wr_stat) begin
        irq_stat <= (irq_stat & ~hwdata[`CEN_IRQ_W-1:0]) | irq_set;
      end else begin
        irq_stat <= irq_stat | irq_set;
      end
      irq <= |(irq_stat & irq_mask);
    end
  end

  // ---------------------------------------------------------------
  // read data, taken in the address phase
  // ---------------------------------------------------------------
  reg [31:0] rd_val;
  reg [NE-1:0] en_vec;
  always @* begin
    en_vec = enabled;
    rd_val = 32'h0000_0000;
    case (haddr)
      `CEN_OFS_PICK: rd_val[3:0] = event_pick;
      `CEN_OFS_NOTIFY: rd_val[1:0] = notify_setting[event_pick];
      `CEN_OFS_LIMIT: rd_val[CNT_W-1:0] = counter_limit;
      `CEN_OFS_IRQ_STAT: rd_val[`CEN_IRQ_W-1:0] = irq_stat;
      `CEN_OFS_IRQ_MASK: rd_val[`CEN_IRQ_W-1:0] = irq_mask;
      `CEN_OFS_STATUS: begin
        rd_val[NE-1:0] = en_vec;
        rd_val[16+FIFO_AW:16] = fifo_level;
        rd_val[31] = msg_valid;
      end
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_take) begin
      hrdata <= rd_val;
    end
  end

endmodule // cen_notifier

// File: rtl/cen_defs.vh
// constants of the camera event notifier
`ifndef CEN_DEFS_VH
`define CEN_DEFS_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define CEN_OFS_PICK 8'h00
`define CEN_OFS_NOTIFY 8'h04
`define CEN_OFS_LIMIT 8'h08
`define CEN_OFS_IRQ_STAT 8'h0c
`define CEN_OFS_IRQ_MASK 8'h10
`define CEN_OFS_STATUS 8'h14

// ---------------------------------------------------------------
// event type codes, as seen in event_pick and on msg_code
// ---------------------------------------------------------------
`define CEN_EVT_FRAME_BEGIN 4'h0
`define CEN_EVT_EXP_BEGIN 4'h1
`define CEN_EVT_EXP_FINISH 4'h2
`define CEN_EVT_ACQ_REARM 4'h3
`define CEN_EVT_TRIG_OK 4'h4
`define CEN_EVT_TRIG_REJ 4'h5
`define CEN_EVT_LOST_IMAGE 4'h6
`define CEN_EVT_CNT_TERM 4'h7
`define CEN_EVT_IN_A_RISE 4'h8
`define CEN_EVT_IN_A_FALL 4'h9
`define CEN_EVT_IN_B_RISE 4'ha
`define CEN_EVT_IN_B_FALL 4'hb
`define CEN_EVT_OVERFLOW 4'hc
`define CEN_NUM_EVT 13

// ---------------------------------------------------------------
// notify_setting values
// ---------------------------------------------------------------
`define CEN_NOTIFY_OFF 2'h0
`define CEN_NOTIFY_ON 2'h1
`define CEN_NOTIFY_LEGACY 2'h2

// ---------------------------------------------------------------
// interrupt status bits, counter_limit reset value, default queue depth
// ---------------------------------------------------------------
`define CEN_IRQ_OVERFLOW 0
`define CEN_IRQ_TRIG_REJ 1
`define CEN_IRQ_LOST_IMAGE 2
`define CEN_IRQ_W 3
`define CEN_LIMIT_RESET 16'h0000
`define CEN_FIFO_DEPTH 8

`endif

// File: rtl/cen_edge_detect.v
// rising and falling edge pulses for a set of input lines
`timescale 1ns/10ps
module cen_edge_detect #(
  parameter N = 2
) (
  input wire hclk,
  input wire hresetn,
  input wire [N-1:0] line_in,
  output reg [N-1:0] rise,
  output reg [N-1:0] fall
);
  reg [N-1:0] line_q;
  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_line
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          line_q[i] <= 1'b0;
          rise[i] <= 1'b0;
          fall[i] <= 1'b0;
        end else begin
          line_q[i] <= line_in[i];
          rise[i] <= line_in[i] & ~line_q[i];
          fall[i] <= ~line_in[i] & line_q[i];
        end
      end
    end
  endgenerate
endmodule // cen_edge_detect

// File: rtl/cen_msg_fifo.v
// first-in first-out queue of pending event messages
`timescale 1ns/10ps
module cen_msg_fifo #(
  parameter W = 4,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire hclk,
  input wire hresetn,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data,
  output reg [AW:0] level
);
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  wire push;
  wire pop;
  assign in_ready = (level != DEPTH[AW:0]);
  assign out_valid = (level != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge hclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      level <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                  wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                  rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        level <= level + 1'b1;
      end else if (pop && !push) begin
        level <= level - 1'b1;
      end
    end
  end
endmodule // cen_msg_fifo

// File: verif/cen_notifier_monitor.sv
// port checker of the camera event notifier
`timescale 1ns/10ps
module cen_notifier_monitor (
  input logic hclk,
  input logic hresetn,
  input logic hsel,
  input logic [1:0] htrans,
  input logic hreadyout,
  input logic hresp,
  input logic frame_trigger,
  input logic trigger_invalid_region,
  input logic frame_acq_start,
  input logic msg_valid,
  input logic [3:0] msg_code,
  input logic msg_ready
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ---------------------------------------------------------------
  // sequences
  // ---------------------------------------------------------------
  sequence s_good_trig;
    frame_trigger && !trigger_invalid_region;
  endsequence
  sequence s_bad_trig;
    frame_trigger && trigger_invalid_region;
  endsequence
  sequence s_stall;
    msg_valid && !msg_ready;
  endsequence
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_zero_wait: assert property (hsel && htrans[1] |=> hreadyout)
    else $error("wait state on register bus");
  a_resp_okay: assert property (hreadyout |-> !hresp)
    else $error("error response on register bus");
  a_trig_accept: assert property (s_good_trig |=> frame_acq_start)
    else $error("accepted trigger started no frame");
  a_trig_reject: assert property (s_bad_trig |=> !frame_acq_start)
    else $error("rejected trigger started a frame");
  a_acq_cause: assert property (frame_acq_start |->
    $past(frame_trigger && !trigger_invalid_region))
    else $error("frame start without a trigger");
  a_acq_single: assert property (frame_acq_start && !frame_trigger
    |=> !frame_acq_start)
    else $error("frame start longer than one cycle");
  a_msg_hold: assert property (s_stall |=> msg_valid && $stable(msg_code))
    else $error("pending message changed before taken");
  a_code_range: assert property (msg_valid |-> msg_code <= 4'hc)
    else $error("message code out of range");
endmodule // cen_notifier_monitor

// File: verif/cen_host_model.sv
// host side receiver of control channel messages
`timescale 1ns/10ps
module cen_host_model (
  input logic hclk,
  input logic hresetn,
  input logic stall,
  input logic msg_valid,
  input logic [3:0] msg_code,
  output logic msg_ready,
  output int got,
  output logic [3:0] last_code
);
  // stall lets the bench back up the queue on purpose
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      msg_ready <= 1'b0;
      got <= 0;
      last_code <= 4'h0;
    end else begin
      msg_ready <= !stall;
      if (msg_valid && msg_ready) begin
        got <= got + 1;
        last_code <= msg_code;
      end
    end
  end
endmodule // cen_host_model

// File: verif/tb.sv
// self-checking bench of the camera event notifier
`timescale 1ns/10ps
`include "cen_defs.vh"
module tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [7:0] pls = 8'h00;
  logic in_a = 1'b0;
  logic in_b = 1'b0;
  logic stall = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, irq, frame_acq_start, msg_valid, msg_ready;
  logic [3:0] msg_code, last_code;
  logic [31:0] v;
  logic [1:0] row_set [12];
  logic [3:0] row_exp [12];
  int got, n0;
  int err_total = 0;
  int comparisons = 0;

  always #2.5 hclk = ~hclk;

  cen_notifier #(.FIFO_DEPTH(2), .FIFO_AW(1), .CNT_W(16)) i_cen_notifier (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .irq(irq), .exp_delay_start(pls[0]),
    .exposure_start(pls[1]), .exposure_end(pls[2]),
    .acq_begin_cmd_ok(pls[3]), .frame_trigger(pls[4] | pls[5]),
    .trigger_invalid_region(pls[5]), .image_dropped(pls[6]),
    .counter_tick(pls[7]), .in_a(in_a), .in_b(in_b),
    .frame_acq_start(frame_acq_start), .msg_valid(msg_valid),
    .msg_code(msg_code), .msg_ready(msg_ready));

  cen_host_model i_cen_host_model (
    .hclk(hclk), .hresetn(hresetn), .stall(stall), .msg_valid(msg_valid),
    .msg_code(msg_code), .msg_ready(msg_ready), .got(got),
    .last_code(last_code));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, s);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic ap(input logic [7:0] a, input logic w);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ap(a, 1'b1);
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    ap(a, 1'b0);
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask
  // source c of the event table: pulses, or a level step on a line
  task automatic fire(input int c);
    @(posedge hclk);
    if (c < 8) pls[c] <= 1'b1;
    else if (c < 10) in_a <= (c == 8);
    else in_b <= (c == 10);
    @(posedge hclk);
    pls <= 8'h00;
  endtask
  task automatic wait_msg(input int n);
    int k;
    k = 0;
    while (got < n && k < 20) begin
      @(posedge hclk);
      k++;
    end
  endtask
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #100000;
    err_total++;
    stop_test();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    row_set = '{1, 2, 1, 2, 1, 2, 1, 2, 1, 2, 1, 2};
    row_exp = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5,
                4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb};
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`CEN_OFS_NOTIFY, v);
    chk("notify_reset", 0, v);
    rd(8'h18, v);
    chk("unmapped", 0, v);
    wr(`CEN_OFS_LIMIT, 32'h1);
    for (int i = 0; i < 12; i++) begin
      wr(`CEN_OFS_PICK, 32'(i));
      wr(`CEN_OFS_NOTIFY, {30'h0, row_set[i]});
      n0 = got;
      fire(i);
      wait_msg(n0 + 1);
      chk("msg_code", {28'h0, row_exp[i]}, {28'h0, last_code});
      chk("msg_count", n0 + 1, got);
      wr(`CEN_OFS_NOTIFY, 32'h0);
    end
    // refused event_pick write and sticky interrupt status
    wr(`CEN_OFS_PICK, 32'd13);
    rd(`CEN_OFS_PICK, v);
    chk("pick_range", 32'hb, v);
    rd(`CEN_OFS_IRQ_STAT, v);
    chk("stat_sticky", 32'h6, v);
    // counter end point: nothing before the third tick, one event at it
    wr(`CEN_OFS_LIMIT, 32'h3);
    wr(`CEN_OFS_PICK, 32'h7);
    wr(`CEN_OFS_NOTIFY, 32'h1);
    n0 = got;
    fire(7);
    fire(7);
    repeat (10) @(posedge hclk);
    chk("cnt_early", n0, got);
    fire(7);
    wait_msg(n0 + 1);
    chk("cnt_term", `CEN_EVT_CNT_TERM, last_code);
    wr(`CEN_OFS_NOTIFY, 32'h0);
    // messages leave in the order their events occurred
    wr(`CEN_OFS_PICK, 32'h6);
    wr(`CEN_OFS_NOTIFY, 32'h1);
    wr(`CEN_OFS_PICK, 32'h3);
    wr(`CEN_OFS_NOTIFY, 32'h1);
    n0 = got;
    fire(6);
    fire(3);
    wait_msg(n0 + 2);
    chk("order_count", n0 + 2, got);
    chk("order_last", `CEN_EVT_ACQ_REARM, last_code);
    wr(`CEN_OFS_NOTIFY, 32'h0);
    wr(`CEN_OFS_PICK, 32'h6);
    wr(`CEN_OFS_NOTIFY, 32'h0);
    wr(`CEN_OFS_PICK, 32'h1);
    wr(`CEN_OFS_NOTIFY, 32'h1);
    wr(`CEN_OFS_NOTIFY, 32'h3);
    wr(`CEN_OFS_PICK, 32'h2);
    wr(`CEN_OFS_NOTIFY, 32'h2);
    rd(`CEN_OFS_STATUS, v);
    chk("enabled", 32'h6, v & 32'h1fff);
    wr(`CEN_OFS_PICK, 32'h1);
    rd(`CEN_OFS_NOTIFY, v);
    chk("notify_pick", 32'h1, v);
    // a disabled type stays silent
    n0 = got;
    fire(0);
    repeat (12) @(posedge hclk);
    chk("silent", n0, got);
    // host stalls until the queue overflows
    stall <= 1'b1;
    repeat (6) fire(1);
    repeat (4) @(posedge hclk);
    wr(`CEN_OFS_IRQ_MASK, 32'h1);
    repeat (2) @(posedge hclk);
    chk("irq_overflow", 1, irq);
    stall <= 1'b0;
    repeat (30) @(posedge hclk);
    chk("last_code", `CEN_EVT_OVERFLOW, last_code);
    rd(`CEN_OFS_STATUS, v);
    chk("all_off", 0, v & 32'h1fff);
    wr(`CEN_OFS_IRQ_STAT, 32'h1);
    repeat (2) @(posedge hclk);
    chk("irq_clear", 0, irq);
    n0 = got;
    fire(1);
    repeat (12) @(posedge hclk);
    chk("stays_off", n0, got);
    // nothing comes back until the host enables it again
    wr(`CEN_OFS_PICK, 32'h1);
    wr(`CEN_OFS_NOTIFY, 32'h1);
    n0 = got;
    fire(1);
    wait_msg(n0 + 1);
    chk("reenabled", `CEN_EVT_EXP_BEGIN, last_code);
    // second reset in mid-run clears the settings
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`CEN_OFS_STATUS, v);
    chk("enabled_reset", 0, v & 32'h1fff);
    stop_test();
  end
endmodule // tb

bind cen_notifier cen_notifier_monitor i_mon (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hreadyout(hreadyout), .hresp(hresp), .frame_trigger(frame_trigger),
  .trigger_invalid_region(trigger_invalid_region),
  .frame_acq_start(frame_acq_start), .msg_valid(msg_valid),
  .msg_code(msg_code), .msg_ready(msg_ready));
